// file: rtl/rotate_sub_swap_xor_sleep_ops.sv
// holds the execution block: accumulator, file registers, status flags, watchdog and sleep control
// assumes an AXI4-Lite master on ref_clk; commands come in through the command register
//
// Behaviour
// [RL1] left rotate moves file operand up, carry into bit 0, bit 7 to carry
// [RL2] right rotate moves file operand down, carry into bit 7, bit 0 to carry
// [RL3] file-operand results go to accumulator when destination bit is 0, else file
// [RL4] sleep clears the watchdog counter and its prescaler
// [RL5] sleep clears power-down bit, sets timeout bit, halts with oscillator stopped
// [RL6] literal minus accumulator goes to accumulator; carry, digit carry, zero updated
// [RL7] file minus accumulator goes to destination; carry, digit carry, zero updated
// [RL8] nibble exchange swaps the file operand's halves, no flag changes
// [RL9] accumulator xor literal goes to accumulator; only zero flag updated
// [RL10] accumulator xor file goes to destination; only zero flag updated
// [RL11] subtract carry and digit carry are set on no borrow, cleared on borrow
`timescale 1ns/1ps
`include "core_ops_map.svh"
module rotate_sub_swap_xor_sleep_ops
  import core_ops_pkg::*;
#(
  parameter int ADDR_W  = 8,
  parameter int FADDR_W = 7,
  parameter int WDT_W   = 8,
  parameter int PRESC_W = 8
) (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   sleep_mode,
  output logic                   osc_enable
);

  localparam int FILE_DEPTH = 1 << FADDR_W;

  // ------------------------------------------------------------
  // parameter checks
  // ------------------------------------------------------------
  if (ADDR_W < 8) $error("ADDR_W must be at least 8");
  if (FADDR_W < 1 || FADDR_W > 7) $error("FADDR_W must be 1 to 7");
  if (WDT_W < 1 || WDT_W > 16) $error("WDT_W must be 1 to 16");
  if (PRESC_W < 1 || PRESC_W > 16) $error("PRESC_W must be 1 to 16");

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  logic [7:0]         aw_addr, next_aw_addr;
  logic               aw_full, next_aw_full;
  logic [31:0]        w_data, next_w_data;
  logic [3:0]         w_strb, next_w_strb;
  logic               w_full, next_w_full;
  logic               next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]         next_bresp, next_rresp;
  logic [31:0]        next_rdata;
  logic               wr_fire;
  logic               wr_err;
  logic [31:0]        rd_word;
  logic               rd_err;

  logic [7:0]         acc, next_acc;
  logic [4:0]         status, next_status;
  logic [31:0]        cmd, next_cmd;
  logic               pending, next_pending;
  logic [FADDR_W-1:0] file_idx, next_file_idx;
  logic [WDT_W-1:0]   wdt, next_wdt;
  logic [PRESC_W-1:0] presc, next_presc;
  logic               next_sleep, next_osc;
  logic               file_we;
  logic [FADDR_W-1:0] file_wa;
  logic [7:0]         file_wd;
  logic [7:0]         file_mem [FILE_DEPTH];
  logic [FADDR_W-1:0] cmd_faddr;

  op_unit_if ou ();

  // merge a written word into an old one by byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[i*8 +: 8] = new_w[i*8 +: 8];
      end
    end
    return m;
  endfunction

  // ------------------------------------------------------------
  // operation unit
  // ------------------------------------------------------------
  assign cmd_faddr = cmd[`CMD_FADDR_LSB +: FADDR_W];
  assign ou.op     = op_t'(cmd[`CMD_OP]);
  assign ou.fval   = file_mem[cmd_faddr];
  assign ou.wval   = acc;
  assign ou.lit    = cmd[`CMD_LIT];
  assign ou.c_in   = status[`ST_C];

  op_unit u_op_unit (
    .u (ou.unit)
  );

  // ------------------------------------------------------------
  // bus write and read channels
  // ------------------------------------------------------------
  assign wr_fire = aw_full && w_full && !s_axi_bvalid;

  // decode a read address into a word and an error
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_err  = 1'b0;
    unique case (s_axi_araddr[7:0])
      `REG_ACC:       rd_word[7:0] = acc;
      `REG_STATUS:    rd_word[5:0] = {sleep_mode, status};
      `REG_CMD:       rd_word      = cmd;
      `REG_FILE_IDX:  rd_word[FADDR_W-1:0] = file_idx;
      `REG_FILE_DATA: rd_word[7:0] = file_mem[file_idx];
      `REG_WDT: begin
        rd_word[`WDT_CNT_LSB +: WDT_W]   = wdt;
        rd_word[`WDT_PRE_LSB +: PRESC_W] = presc;
      end
      default:        rd_err = 1'b1;
    endcase
  end

  // write address check for the response code
  always_comb begin
    unique case (aw_addr)
      `REG_ACC, `REG_STATUS, `REG_CMD, `REG_FILE_IDX, `REG_FILE_DATA, `REG_WDT: wr_err = 1'b0;
      default: wr_err = 1'b1;
    endcase
  end

  // next values of the bus handshake state
  always_comb begin
    next_aw_addr = aw_addr;
    next_aw_full = aw_full;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_w_full  = w_full;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rdata   = s_axi_rdata;
    next_rresp   = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = wr_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // register the bus handshake state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      aw_addr       <= 8'h00;
      aw_full       <= 1'b0;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      w_full        <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      aw_addr       <= next_aw_addr;
      aw_full       <= next_aw_full;
      w_data        <= next_w_data;
      w_strb        <= next_w_strb;
      w_full        <= next_w_full;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ------------------------------------------------------------
  // core state: software writes, execution, watchdog
  // ------------------------------------------------------------
  always_comb begin
    logic [31:0] wmerged;
    wmerged       = merge(32'h0000_0000, w_data, w_strb);
    next_acc      = acc;
    next_status   = status;
    next_cmd      = cmd;
    next_pending  = 1'b0;
    next_file_idx = file_idx;
    next_sleep    = sleep_mode;
    next_presc    = presc + 1'b1;
    next_wdt      = (&presc) ? wdt + 1'b1 : wdt;
    file_we       = 1'b0;
    file_wa       = file_idx;
    file_wd       = w_data[7:0];
    // software side; a command while asleep only wakes the core
    if (wr_fire && !wr_err) begin
      unique case (aw_addr)
        `REG_ACC:       if (w_strb[0]) next_acc = w_data[7:0];
        `REG_STATUS: begin
          if (w_strb[0]) next_status = (status & ~`ST_SW_MASK) | (w_data[4:0] & `ST_SW_MASK);
        end
        `REG_CMD: begin
          if (sleep_mode) begin
            next_sleep = 1'b0;
          end else begin
            next_cmd     = merge(cmd, w_data, w_strb) & `CMD_MASK;
            next_pending = 1'b1;
          end
        end
        `REG_FILE_IDX:  if (w_strb[0]) next_file_idx = w_data[FADDR_W-1:0];
        `REG_FILE_DATA: file_we = w_strb[0];
        `REG_WDT: begin
          if (|wmerged) begin
            next_wdt   = '0;
            next_presc = '0;
          end
        end
        default: next_acc = acc;
      endcase
    end
    // watchdog overflow: timeout shows, core wakes
    if ((&presc) && (&wdt)) begin
      next_status[`ST_TO] = 1'b0;
      next_sleep          = 1'b0;
    end
    // execute the pending command; hardware wins over a software write
    if (pending) begin
      if (ou.op == sleep_op) begin
        next_wdt            = '0;                       // see [RL4]
        next_presc          = '0;                       // see [RL4]
        next_status[`ST_PD] = 1'b0;                     // see [RL5]
        next_status[`ST_TO] = 1'b1;                     // see [RL5]
        next_sleep          = 1'b1;                     // see [RL5]
      end
      if (ou.upd_c)  next_status[`ST_C]  = ou.c_out;    // see [RL1] see [RL2] see [RL11]
      if (ou.upd_dc) next_status[`ST_DC] = ou.dc_out;   // see [RL11]
      if (ou.upd_z)  next_status[`ST_Z]  = ou.z_out;    // see [RL6] see [RL9]
      if (ou.has_result) begin
        if (ou.file_form && cmd[`CMD_DEST] != `DEST_ACC) begin
          file_we = 1'b1;                               // see [RL3]
          file_wa = cmd_faddr;
          file_wd = ou.result;
        end else begin
          next_acc = ou.result;                         // see [RL3] see [RL6]
        end
      end
    end
    next_osc = !next_sleep;                             // see [RL5]
  end

  // register the core state
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc        <= 8'h00;
      status     <= `STATUS_RST;
      cmd        <= 32'h0000_0000;
      pending    <= 1'b0;
      file_idx   <= '0;
      wdt        <= '0;
      presc      <= '0;
      sleep_mode <= 1'b0;
      osc_enable <= 1'b1;
    end else begin
      acc        <= next_acc;
      status     <= next_status;
      cmd        <= next_cmd;
      pending    <= next_pending;
      file_idx   <= next_file_idx;
      wdt        <= next_wdt;
      presc      <= next_presc;
      sleep_mode <= next_sleep;
      osc_enable <= next_osc;
    end
  end

  // file register array, one write port
  always_ff @(posedge ref_clk) begin
    if (file_we) begin
      file_mem[file_wa] <= file_wd;
    end
  end

endmodule // rotate_sub_swap_xor_sleep_ops

// file: rtl/core_ops_map.svh
// holds the register map, field positions, reset values and bus codes of the execution block
// assumes it is included by its bare name wherever these names are needed
`ifndef CORE_OPS_MAP_SVH
`define CORE_OPS_MAP_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define REG_ACC        8'h00
`define REG_STATUS     8'h04
`define REG_CMD        8'h08
`define REG_FILE_IDX   8'h0C
`define REG_FILE_DATA  8'h10
`define REG_WDT        8'h14

// ------------------------------------------------------------
// status register fields
// ------------------------------------------------------------
`define ST_C           0
`define ST_DC          1
`define ST_Z           2
`define ST_PD          3
`define ST_TO          4
`define ST_SLEEP       5
`define ST_SW_MASK     5'h07
`define STATUS_RST     5'h18

// ------------------------------------------------------------
// command register fields
// ------------------------------------------------------------
`define CMD_OP         3:0
`define CMD_DEST       4
`define CMD_FADDR_LSB  8
`define CMD_LIT        23:16
`define CMD_MASK       32'h00FF7F1F

// ------------------------------------------------------------
// watchdog register fields, bus answers and the accumulator destination code
// ------------------------------------------------------------
`define WDT_CNT_LSB    0
`define WDT_PRE_LSB    16
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`define DEST_ACC       1'b0

`endif

// file: rtl/core_ops_pkg.sv
// holds the operation type shared by the execution block and its operation unit
// assumes nothing beyond a SystemVerilog compiler
package core_ops_pkg;

  // ------------------------------------------------------------
  // operations carried by the command register
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    rotate_left_thru_carry,
    rotate_right_thru_carry,
    literal_minus_accumulator,
    file_minus_accumulator,
    nibble_exchange,
    accumulator_xor_literal,
    accumulator_xor_file,
    sleep_op
  } op_t;

endpackage

// file: rtl/op_unit_if.sv
// holds the interface between the execution block and its operation unit
// assumes the unit is purely combinational and answers in the same cycle
`timescale 1ns/1ps
interface op_unit_if;
  import core_ops_pkg::*;

  op_t        op;
  logic [7:0] fval;
  logic [7:0] wval;
  logic [7:0] lit;
  logic       c_in;
  logic [7:0] result;
  logic       c_out;
  logic       dc_out;
  logic       z_out;
  logic       upd_c;
  logic       upd_dc;
  logic       upd_z;
  logic       has_result;
  logic       file_form;

  modport core (output op, fval, wval, lit, c_in,
                input  result, c_out, dc_out, z_out, upd_c, upd_dc, upd_z, has_result, file_form);
  modport unit (input  op, fval, wval, lit, c_in,
                output result, c_out, dc_out, z_out, upd_c, upd_dc, upd_z, has_result, file_form);
endinterface

// file: rtl/op_unit.sv
// holds the combinational arithmetic and logic of the execution block
// assumes operands are stable for the cycle in which the core consumes the answer
`timescale 1ns/1ps
module op_unit
  import core_ops_pkg::*;
(
  op_unit_if.unit u
);

  logic [8:0] diff;
  logic [4:0] low_diff;
  logic [7:0] minuend;

  // ------------------------------------------------------------
  // subtract: minuend plus inverted accumulator plus one
  // ------------------------------------------------------------
  assign minuend  = (u.op == literal_minus_accumulator) ? u.lit : u.fval;
  assign diff     = {1'b0, minuend} + {1'b0, ~u.wval} + 9'h001;
  assign low_diff = {1'b0, minuend[3:0]} + {1'b0, ~u.wval[3:0]} + 5'h01;

  // select the result and which flags it touches
  always_comb begin
    u.result     = 8'h00;
    u.c_out      = u.c_in;
    u.dc_out     = 1'b0;
    u.upd_c      = 1'b0;
    u.upd_dc     = 1'b0;
    u.upd_z      = 1'b0;
    u.has_result = 1'b1;
    u.file_form  = 1'b1;
    unique case (u.op)
      rotate_left_thru_carry: begin
        u.result = {u.fval[6:0], u.c_in};             // see [RL1]
        u.c_out  = u.fval[7];
        u.upd_c  = 1'b1;
      end
      rotate_right_thru_carry: begin
        u.result = {u.c_in, u.fval[7:1]};             // see [RL2]
        u.c_out  = u.fval[0];
        u.upd_c  = 1'b1;
      end
      literal_minus_accumulator, file_minus_accumulator: begin
        u.result    = diff[7:0];                      // see [RL6] see [RL7]
        u.c_out     = diff[8];                        // see [RL11]
        u.dc_out    = low_diff[4];                    // see [RL11]
        u.upd_c     = 1'b1;
        u.upd_dc    = 1'b1;
        u.upd_z     = 1'b1;
        u.file_form = (u.op == file_minus_accumulator);
      end
      nibble_exchange: begin
        u.result = {u.fval[3:0], u.fval[7:4]};        // see [RL8]
      end
      accumulator_xor_literal: begin
        u.result    = u.wval ^ u.lit;                 // see [RL9]
        u.upd_z     = 1'b1;
        u.file_form = 1'b0;
      end
      accumulator_xor_file: begin
        u.result = u.wval ^ u.fval;                   // see [RL10]
        u.upd_z  = 1'b1;
      end
      sleep_op: begin
        u.has_result = 1'b0;
        u.file_form  = 1'b0;
      end
      default: begin
        u.has_result = 1'b0;
        u.file_form  = 1'b0;
      end
    endcase
  end

  assign u.z_out = (u.result == 8'h00);

endmodule // op_unit

// file: test/ops_sva.sv
// checker for the execution block: register bus handshakes and sleep outputs
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`include "core_ops_map.svh"
module ops_sva #(
  parameter int ADDR_W = 8
) (
  input wire logic              ref_clk,
  input wire logic              rst,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic [31:0]       s_axi_wdata,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic [1:0]        s_axi_bresp,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic              sleep_mode,
  input wire logic              osc_enable
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic cmd_wr;

  // command word taken on both write channels in one cycle
  assign cmd_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == `REG_CMD;

  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  osc_pair_a: assert property (osc_enable == !sleep_mode)
    else $error("oscillator enable disagrees with sleep state");
  sleep_entry_a: assert property (cmd_wr && s_axi_wdata[3:0] == 4'h7 && !sleep_mode |=> ##2 sleep_mode)
    else $error("sleep command did not stop the core");
  stay_awake_a: assert property (cmd_wr && s_axi_wdata[3:0] != 4'h7 && !sleep_mode |=> ##2 !sleep_mode)
    else $error("core slept without a sleep command");
  sleep_wake_a: assert property (cmd_wr && sleep_mode |=> ##1 !sleep_mode)
    else $error("command write did not wake the core");
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response late");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped before taken");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed before taken");
  wr_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channels open while response pending");
  rd_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address open while data pending");
endmodule // ops_sva

// file: test/rotate_sub_swap_xor_sleep_ops_tb.sv
// self-checking bench for the execution block, driven over its register bus
// assumes the package, interface, design and checker files are compiled first
`timescale 1ns/1ps
`include "core_ops_map.svh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_fail++; $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module rotate_sub_swap_xor_sleep_ops_tb;
  import core_ops_pkg::*;
  logic        ref_clk;
  logic        rst           = 1'b1;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        sleep_mode, osc_enable;
  int          n_fail      = 0;
  int          checks_done = 0;

  rotate_sub_swap_xor_sleep_ops uut (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sleep_mode, .osc_enable);

  // ------------------------------------------------------------
  // bus tasks
  // ------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // one write; bready raised only once the answer shows
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
    s_axi_bready <= 1'b0;
    if (n == 50) begin
      n_fail++;
      test_done();
    end
    `CHK(s_axi_bresp, er)
  endtask

  // one read; rready raised only once the data shows
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge ref_clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
    s_axi_rready <= 1'b0;
    if (n == 50) begin
      n_fail++;
      test_done();
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    `CHK(d, e)
  endtask

  task automatic cmd(input op_t op, input logic d, input logic [6:0] f, input logic [7:0] k);
    wr(`REG_CMD, {8'h00, k, 1'b0, f, 3'h0, d, op}, `RESP_OKAY);
  endtask

  task automatic setf(input logic [6:0] f, input logic [7:0] v);
    wr(`REG_FILE_IDX, {25'h0, f}, `RESP_OKAY);
    wr(`REG_FILE_DATA, {24'h0, v}, `RESP_OKAY);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_rotate();
    chk_rd(`REG_STATUS, 32'h18);
    setf(7'h05, 8'h81);
    wr(`REG_STATUS, 32'h04, `RESP_OKAY);
    cmd(rotate_left_thru_carry, 1'b0, 7'h05, 8'h00);
    chk_rd(`REG_ACC, 32'h02);
    chk_rd(`REG_STATUS, 32'h1D);
    cmd(rotate_right_thru_carry, 1'b1, 7'h05, 8'h00);
    chk_rd(`REG_FILE_DATA, 32'hC0);
    chk_rd(`REG_ACC, 32'h02);
    cmd(rotate_right_thru_carry, 1'b1, 7'h05, 8'h00);
    chk_rd(`REG_FILE_DATA, 32'hE0);
    chk_rd(`REG_STATUS, 32'h1C);
    $display("rotate test done");
  endtask

  task automatic t_sub();
    logic [7:0] k[4] = '{8'h05, 8'h10, 8'h03, 8'h42};
    logic [7:0] w[4] = '{8'h03, 8'h01, 8'h05, 8'h42};
    logic [7:0] q[4] = '{8'h02, 8'h0F, 8'hFE, 8'h00};
    logic [2:0] f[4] = '{3'h3, 3'h1, 3'h0, 3'h7};
    for (int i = 0; i < 4; i++) begin
      wr(`REG_ACC, {24'h0, w[i]}, `RESP_OKAY);
      wr(`REG_STATUS, 32'h0, `RESP_OKAY);
      cmd(literal_minus_accumulator, 1'b1, 7'h00, k[i]);
      chk_rd(`REG_ACC, {24'h0, q[i]});
      chk_rd(`REG_STATUS, {27'h0, 2'b11, f[i]});
    end
    setf(7'h07, 8'h20);
    wr(`REG_ACC, 32'h21, `RESP_OKAY);
    cmd(file_minus_accumulator, 1'b1, 7'h07, 8'h00);
    chk_rd(`REG_FILE_DATA, 32'hFF);
    chk_rd(`REG_STATUS, 32'h18);
    chk_rd(`REG_ACC, 32'h21);
    cmd(file_minus_accumulator, 1'b0, 7'h07, 8'h00);
    chk_rd(`REG_ACC, 32'hDE);
    chk_rd(`REG_STATUS, 32'h1B);
    $display("subtract test done");
  endtask

  task automatic t_swap_xor();
    setf(7'h09, 8'hA5);
    wr(`REG_STATUS, 32'h07, `RESP_OKAY);
    cmd(nibble_exchange, 1'b0, 7'h09, 8'h00);
    chk_rd(`REG_ACC, 32'h5A);
    chk_rd(`REG_STATUS, 32'h1F);
    cmd(nibble_exchange, 1'b1, 7'h09, 8'h00);
    chk_rd(`REG_FILE_DATA, 32'h5A);
    wr(`REG_STATUS, 32'h03, `RESP_OKAY);
    cmd(accumulator_xor_literal, 1'b0, 7'h00, 8'h5A);
    chk_rd(`REG_ACC, 32'h00);
    chk_rd(`REG_STATUS, 32'h1F);
    wr(`REG_ACC, 32'h0F, `RESP_OKAY);
    cmd(accumulator_xor_file, 1'b1, 7'h09, 8'h00);
    chk_rd(`REG_FILE_DATA, 32'h55);
    chk_rd(`REG_STATUS, 32'h1B);
    cmd(accumulator_xor_file, 1'b0, 7'h09, 8'h00);
    chk_rd(`REG_ACC, 32'h5A);
    $display("swap and xor test done");
  endtask

  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0]  r;
    wr(8'h18, 32'hFFFF_FFFF, `RESP_SLVERR);
    rd(8'h18, d, r);
    `CHK(d, 32'h0)
    `CHK(r, `RESP_SLVERR)
    $display("unmapped test done");
  endtask

  // idle past one watchdog overflow: timeout bit shows low; sleep then clears the counter, and a command write wakes the core
  task automatic t_sleep();
    logic [31:0] d;
    logic [1:0]  r;
    repeat (66000) @(posedge ref_clk);
    chk_rd(`REG_STATUS, 32'h0B);
    cmd(sleep_op, 1'b0, 7'h00, 8'h00);
    chk_rd(`REG_STATUS, 32'h33);
    rd(`REG_WDT, d, r);
    `CHK(d[7:0], 8'h00)
    `CHK(d[23:16] < 8'h10, 1'b1)
    `CHK(sleep_mode, 1'b1)
    `CHK(osc_enable, 1'b0)
    cmd(rotate_left_thru_carry, 1'b0, 7'h09, 8'h00);
    @(posedge ref_clk);
    `CHK(sleep_mode, 1'b0)
    `CHK(osc_enable, 1'b1)
    chk_rd(`REG_ACC, 32'h5A);
    chk_rd(`REG_STATUS, 32'h13);
    $display("sleep test done");
  endtask

  // ------------------------------------------------------------
  // clock and main sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    t_rotate();
    t_sub();
    t_swap_xor();
    t_unmapped();
    t_sleep();
    test_done();
  end
endmodule // rotate_sub_swap_xor_sleep_ops_tb

bind rotate_sub_swap_xor_sleep_ops ops_sva #(.ADDR_W(ADDR_W)) chk (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .sleep_mode, .osc_enable);
